// [include/qca_pkg.sv]
// shared constants and carrier types for queue congestion accounting
// assumes one core clock; forwarder and bus logic sit on that clock
package qca_pkg;

   // sizes of the account tables
   localparam int NPORT = 4;               // ports tracked
   localparam int NCLS  = 8;               // qos classes
   localparam int NRES  = 4;               // tracked resources
   localparam int CW    = 15;              // counter and threshold width
   localparam int LW    = 14;              // frame length width, bytes

   // resource numbering inside the sheets
   localparam int RES_IMEM = 0;            // ingress packet memory
   localparam int RES_EMEM = 1;            // egress packet memory
   localparam int RES_IREF = 2;            // ingress frame references
   localparam int RES_EREF = 3;            // egress frame references

   // buffer geometry
   localparam int WORD_BYTES = 184;        // bytes per memory word
   localparam logic [CW:0] POOL_WORDS = 16'h590b;  // 22795 words
   localparam logic [CW:0] POOL_REFS  = 16'h590b;  // 22795 references
   localparam logic [CW-1:0] THR_MAX  = 15'h7fff; // colour threshold that disables the colour check

   // threshold table layout, in word indexes
   localparam int SHEET_STRIDE = 48;       // entries per resource sheet
   localparam int OFS_PC       = 0;        // port-class reservations
   localparam int OFS_PORT     = 32;       // port reservations
   localparam int OFS_CLS      = 36;       // class sharing thresholds
   localparam int OFS_COL      = 44;       // colour thresholds
   localparam int IDX_PFC      = 192;      // pause thresholds per class
   localparam int NTHR         = 200;      // threshold entries
   localparam int IDX_CTRL     = 200;      // control word
   localparam int IDX_TOT      = 204;      // pool totals, read only
   localparam int IDX_SHR      = 208;      // common shared use, read only
   localparam int CTRL_FC_LSB  = 0;        // flow control port mask
   localparam int CTRL_CRE_LSB = 4;        // class_reservation_enable mask
   localparam logic [CW-1:0] THR_RST = 15'h0000;  // threshold reset value

   // one enqueue request per frame copy
   typedef struct packed {
      logic          valid;       // request present
      logic [1:0]    src;         // ingress port
      logic [1:0]    dst;         // egress port
      logic [2:0]    qos;         // ingress qos class
      logic [1:0]    drop_precedence; // colour 0..3
      logic          drop_mode;   // discard even on flow control port
      logic          first_copy;  // first copy of this frame
      logic [LW-1:0] len;         // stored frame size, bytes
   } qca_req_t;

   // one release per dequeued copy
   typedef struct packed {
      logic          valid;       // release present
      logic [1:0]    src;         // ingress port
      logic [1:0]    dst;         // egress port
      logic [2:0]    qos;         // qos class
      logic          last_copy;   // last copy, frees the stored frame
      logic [LW-1:0] len;         // stored frame size, bytes
   } qca_rel_t;

   // admission answer
   typedef struct packed {
      logic valid;                // answer present
      logic accept;               // copy enqueued
      logic discard;              // copy dropped
      logic stall;                // ingress queue must hold
   } qca_dec_t;

   // the four tier counters of one account chain
   typedef struct packed {
      logic [CW-1:0] pc;          // port-class reservation
      logic [CW-1:0] p;           // port reservation
      logic [CW-1:0] cs;          // class sharing
      logic [CW-1:0] cm;          // common shared remainder
   } qca_cnt_t;

endpackage

// [hw/qca_core.sv]
// queue congestion accounting: tiered sheets, admission, pause levels
// assumes a classic wishbone master and a forwarder on clk_i
//
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module qca_core (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [31:0]           wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   // forwarder side
   input  wire qca_pkg::qca_req_t     req_i,
   input  wire qca_pkg::qca_rel_t     rel_i,
   output qca_pkg::qca_dec_t          dec_o,
   // pause requests, one per port and class
   output logic [qca_pkg::NPORT*qca_pkg::NCLS-1:0] pause_o
);
   import qca_pkg::*;

   // whole module state
   // one flat struct keeps every register in a single flop process
   typedef struct packed {
      logic [NTHR-1:0][CW-1:0]                  thr;   // threshold table
      logic [NPORT-1:0]                         fc;    // flow control ports
      logic [NPORT-1:0]                         cre;   // class reservation
      logic [NRES-1:0][NPORT*NCLS-1:0][CW-1:0]  pc;    // port-class use
      logic [NRES-1:0][NPORT-1:0][CW-1:0]       p;     // port use
      logic [NRES-1:0][NCLS-1:0][CW-1:0]        cs;    // class share use
      logic [NRES-1:0][CW-1:0]                  cm;    // common share use
      logic [NRES-1:0][CW-1:0]                  tot;   // pool use
      logic [NPORT*NCLS-1:0][CW-1:0]            pfc;   // pause sheet use
      logic [NPORT*NCLS-1:0]                    pause; // pause levels
      qca_dec_t                                 dec;   // answer
      logic                                     ack;   // bus ack
      logic [31:0]                              dat;   // bus read data
   } qca_state_t;

   qca_state_t q_reg;   // registered state
   qca_state_t q_next;  // next state

   // smaller of two counts
   function automatic logic [CW-1:0] umin(input logic [CW-1:0] a,
                                           input logic [CW-1:0] b);
      return (a < b) ? a : b;
   endfunction

   // worst case 16383 + 183 bytes still fits the counter width
   // whole words per stored frame
   function automatic logic [CW-1:0] frame_words(input logic [LW-1:0] len);
      logic [CW-1:0] l;
      l = {1'b0, len} + CW'(WORD_BYTES - 1);
      return l / CW'(WORD_BYTES);
   endfunction

   // ingress resources key on source port
   function automatic logic res_ingress(input int r);
      return (r == RES_IMEM) || (r == RES_IREF);
   endfunction

   // units a copy costs on one resource
   function automatic logic [CW-1:0] amount(input int r, input logic once,
                                            input logic [CW-1:0] words);
      case (r)
         RES_IMEM: amount = once ? words : '0;
         RES_EMEM: amount = words;
         default:  amount = 15'h0001;
      endcase
   endfunction

   // threshold table index inside a sheet
   function automatic int tix(input int r, input int ofs, input int k);
      return r * SHEET_STRIDE + ofs + k;
   endfunction

   // fill tiers in order, overflow to next
   function automatic qca_cnt_t charge(input qca_cnt_t c,
                                       input logic [CW-1:0] rpc,
                                       input logic [CW-1:0] rp,
                                       input logic use_cs,
                                       input logic [CW-1:0] rcs,
                                       input logic [CW-1:0] a);
      qca_cnt_t      n;
      logic [CW-1:0] rem;
      logic [CW-1:0] t;
      n   = c;
      rem = a;
      // port-class reservation first
      t    = umin(rem, (rpc > c.pc) ? rpc - c.pc : '0);
      n.pc = c.pc + t;
      rem  = rem - t;
      // then the port reservation
      t    = umin(rem, (rp > c.p) ? rp - c.p : '0);
      n.p  = c.p + t;
      rem  = rem - t;
      t    = use_cs ? umin(rem, (rcs > c.cs) ? rcs - c.cs : '0) : '0;
      n.cs = c.cs + t;
      rem  = rem - t;
      // remainder to common pool
      n.cm = c.cm + rem;
      return n;
   endfunction

   // release order differs from charge order; sums still balance
   // give back, last tier first
   function automatic qca_cnt_t release_units(input qca_cnt_t c,
                                              input logic [CW-1:0] a);
      qca_cnt_t      n;
      logic [CW-1:0] rem;
      logic [CW-1:0] t;
      n    = c;
      rem  = a;
      t    = umin(rem, c.cm);
      n.cm = c.cm - t;
      rem  = rem - t;
      t    = umin(rem, c.cs);
      n.cs = c.cs - t;
      rem  = rem - t;
      t    = umin(rem, c.p);
      n.p  = c.p - t;
      rem  = rem - t;
      n.pc = c.pc - umin(rem, c.pc);
      return n;
   endfunction

   // next state
   // releases land before the request is judged, so a freed unit
   // is usable by a copy presented in the same cycle
   always_comb begin
      logic [7:0]      idx;
      logic            bus_req;
      logic [CW-1:0]   w_req;
      logic [CW-1:0]   w_rel;
      logic [CW-1:0]   amt;
      logic [CW-1:0]   shr;
      logic [CW-1:0]   cls_thr;
      logic [CW-1:0]   col_thr;
      logic [1:0]      pt;
      logic [4:0]      pi;
      logic            cls_open;
      logic            col_open;
      logic            pool_ok;
      logic            allow;
      logic [NRES-1:0] ok;
      qca_cnt_t        c;
      idx      = wb_adr_i[9:2];
      bus_req  = wb_cyc_i & wb_stb_i;
      w_req    = frame_words(req_i.len);
      w_rel    = frame_words(rel_i.len);
      amt      = '0;
      shr      = '0;
      cls_thr  = '0;
      col_thr  = '0;
      pt       = '0;
      pi       = '0;
      cls_open = 1'b0;
      col_open = 1'b0;
      pool_ok  = 1'b0;
      allow    = 1'b0;
      ok       = '0;
      c        = '0;
      q_next   = q_reg;

      // bus: ack one cycle after strobe, dropped after one
      // back to back strobes get an ack every second cycle
      q_next.ack = bus_req & ~q_reg.ack;
      q_next.dat = '0;
      if (bus_req && !q_reg.ack && !wb_we_i) begin
         // read data prepared for the ack cycle
         // unmapped indexes leave the data at zero
         if (int'(idx) < NTHR) begin
            q_next.dat = {17'h00000, q_reg.thr[idx]};
         end else if (int'(idx) == IDX_CTRL) begin
            q_next.dat = {24'h000000, q_reg.cre, q_reg.fc};
         end else if (idx[7:2] == 6'(IDX_TOT / 4)) begin
            q_next.dat = {17'h00000, q_reg.tot[idx[1:0]]};
         end else if (idx[7:2] == 6'(IDX_SHR / 4)) begin
            q_next.dat = {17'h00000, q_reg.cm[idx[1:0]]};
         end
      end
      // write lands on the ack edge, byte lanes honoured
      // read-only and unmapped indexes ignore writes, still acked
      if (bus_req && q_reg.ack && wb_we_i) begin
         if (int'(idx) < NTHR) begin
            if (wb_sel_i[0]) begin
               q_next.thr[idx][7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               q_next.thr[idx][14:8] = wb_dat_i[14:8];
            end
         end else if (int'(idx) == IDX_CTRL && wb_sel_i[0]) begin
            q_next.fc  = wb_dat_i[CTRL_FC_LSB +: NPORT];
            q_next.cre = wb_dat_i[CTRL_CRE_LSB +: NPORT];
         end
      end

      // releases first, one sheet per resource
      for (int r = 0; r < NRES; r++) begin
         pt  = res_ingress(r) ? rel_i.src : rel_i.dst;
         pi  = {pt, rel_i.qos};
         amt = amount(r, rel_i.last_copy, w_rel);
         c   = '{pc: q_next.pc[r][pi], p: q_next.p[r][pt],
                 cs: q_next.cs[r][rel_i.qos], cm: q_next.cm[r]};
         if (rel_i.valid) begin
            c                         = release_units(c, amt);
            q_next.pc[r][pi]          = c.pc;
            q_next.p[r][pt]           = c.p;
            q_next.cs[r][rel_i.qos]   = c.cs;
            q_next.cm[r]              = c.cm;
            q_next.tot[r]             = q_next.tot[r] - umin(amt, q_next.tot[r]);
         end
      end
      // pause sheet gives back ingress memory
      if (rel_i.valid && rel_i.last_copy) begin
         pi = {rel_i.src, rel_i.qos};
         q_next.pfc[pi] = q_next.pfc[pi] - umin(w_rel, q_next.pfc[pi]);
      end

      // evaluate each resource on its own sheet
      for (int r = 0; r < NRES; r++) begin
         pt  = res_ingress(r) ? req_i.src : req_i.dst;
         pi  = {pt, req_i.qos};
         amt = amount(r, req_i.first_copy, w_req);
         shr = q_next.cm[r];
         for (int k = 0; k < NCLS; k++) begin
            shr = shr + q_next.cs[r][k];
         end
         cls_thr = q_next.thr[tix(r, OFS_CLS, int'(req_i.qos))];
         col_thr = q_next.thr[tix(r, OFS_COL, int'(req_i.drop_precedence))];
         // strict mode lets a busy high class starve lower ones
         // strict mode: total shared use (common plus all class shares) against class level
         // a zero threshold keeps this share closed
         cls_open = q_next.cre[pt] ? (q_next.cs[r][req_i.qos] < cls_thr)
                                   : (shr < cls_thr);
         // maximum colour level disables the colour test
         col_open = (col_thr == THR_MAX) || (shr < col_thr);
         // one extra bit so the sum cannot wrap before the compare
         // closes this sheet at the physical pool; its use can still pass it if the other sheet of the pair admits
         pool_ok = ({1'b0, q_next.tot[r]} + {1'b0, amt}) <=
                   ((r == RES_IMEM || r == RES_EMEM) ? POOL_WORDS : POOL_REFS);
         // test fullness before the frame is added
         ok[r] = pool_ok &&
                 ((q_next.pc[r][pi] < q_next.thr[tix(r, OFS_PC, int'(pi))]) ||
                  (q_next.p[r][pt] < q_next.thr[tix(r, OFS_PORT, int'(pt))]) ||
                  (cls_open && col_open));
      end
      // memory and reference both must allow
      allow = (ok[RES_IMEM] | ok[RES_EMEM]) & (ok[RES_IREF] | ok[RES_EREF]);

      for (int r = 0; r < NRES; r++) begin
         pt  = res_ingress(r) ? req_i.src : req_i.dst;
         pi  = {pt, req_i.qos};
         amt = amount(r, req_i.first_copy, w_req);
         c   = '{pc: q_next.pc[r][pi], p: q_next.p[r][pt],
                 cs: q_next.cs[r][req_i.qos], cm: q_next.cm[r]};
         if (req_i.valid && allow) begin
            // excess beyond reservation goes down the tiers
            c = charge(c, q_next.thr[tix(r, OFS_PC, int'(pi))],
                       q_next.thr[tix(r, OFS_PORT, int'(pt))],
                       q_next.cre[pt],
                       q_next.thr[tix(r, OFS_CLS, int'(req_i.qos))], amt);
            q_next.pc[r][pi]        = c.pc;
            q_next.p[r][pt]         = c.p;
            q_next.cs[r][req_i.qos] = c.cs;
            q_next.cm[r]            = c.cm;
            q_next.tot[r]           = q_next.tot[r] + amt;
         end
      end

      // pause level follows this cycle's charge at once
      // pause sheet, own thresholds
      if (req_i.valid && allow && req_i.first_copy) begin
         pi = {req_i.src, req_i.qos};
         q_next.pfc[pi] = q_next.pfc[pi] + w_req;
      end
      for (int k = 0; k < NPORT * NCLS; k++) begin
         q_next.pause[k] = q_next.pfc[k] > q_next.thr[IDX_PFC + (k % NCLS)];
      end

      // answer to the forwarder
      // a stalled copy is re-presented by the forwarder itself
      q_next.dec.valid  = req_i.valid;
      q_next.dec.accept = req_i.valid & allow;
      // flow control ports hold the ingress queue
      q_next.dec.stall   = req_i.valid & ~allow & q_reg.fc[req_i.src]
                           & ~req_i.drop_mode;
      q_next.dec.discard = req_i.valid & ~allow
                           & ~(q_reg.fc[req_i.src] & ~req_i.drop_mode);
   end

   // state register, synchronous reset
   // zero thresholds close every account until programmed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_reg     <= '0;
         q_reg.thr <= {NTHR{THR_RST}};
      end else begin
         q_reg <= q_next;
      end
   end

   // outputs straight from flops
   // fixed one-cycle answer latency towards the forwarder
   assign wb_ack_o = q_reg.ack;
   assign wb_dat_o = q_reg.dat;
   assign dec_o    = q_reg.dec;
   assign pause_o  = q_reg.pause;

endmodule

// [verif/qca_core_asserts.sv]
// port checker for the congestion accounting core
// assumes it is bound to qca_core and shares its single clock
`timescale 1ns/1ps
module qca_core_asserts (
   // clock and reset
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   // register bus
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic [31:0]            wb_dat_o,
   input wire logic                   wb_ack_o,
   // forwarder side
   input wire qca_pkg::qca_req_t      req_i,
   input wire qca_pkg::qca_rel_t      rel_i,
   input wire qca_pkg::qca_dec_t      dec_o,
   input wire logic [31:0]            pause_o
);
   import qca_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held past one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus access not answered next cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("bus ack without request");
   a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   a_dec_answer: assert property (req_i.valid |=> dec_o.valid)
      else $error("copy request not answered next cycle");
   a_dec_cause: assert property (dec_o.valid |-> $past(req_i.valid))
      else $error("decision without request");
   a_dec_onehot: assert property
      (dec_o.valid |-> $onehot({dec_o.accept, dec_o.discard, dec_o.stall}))
      else $error("decision not exactly one outcome");
   a_drop_wins: assert property (dec_o.valid && $past(req_i.drop_mode) |-> !dec_o.stall)
      else $error("drop mode copy stalled");
   a_pause_cause: assert property
      ($changed(pause_o) |-> $past(req_i.valid || rel_i.valid || (wb_cyc_i && wb_stb_i)))
      else $error("pause changed without traffic or bus write");
   a_reset_quiet: assert property
      ($fell(rst_i) |-> !wb_ack_o && !dec_o.valid && pause_o == 32'h0)
      else $error("outputs not quiet after reset");
endmodule

// [verif/qca_fwd_model.sv]
// forwarder stand-in: one copy request or release per call
// assumes tasks are entered just after a rising edge of clk_i
`timescale 1ns/1ps
module qca_fwd_model (
   // clock
   input  wire logic                  clk_i,
   // towards the core
   output qca_pkg::qca_req_t          req_o,
   output qca_pkg::qca_rel_t          rel_o,
   // answer from the core
   input  wire qca_pkg::qca_dec_t     dec_i
);
   import qca_pkg::*;
   // quiet start, valid low
   initial begin
      req_o = '0;
      rel_o = '0;
   end
   // colour and class per copy
   // idle fields inverted so stale values never look current
   task automatic send(input qca_req_t r, output qca_dec_t d);
      req_o <= r;
      @(posedge clk_i);
      req_o <= {1'b0, ~r[$bits(qca_req_t)-2:0]};
      @(posedge clk_i);
      d = dec_i;
   endtask
   // one dequeued copy handed back
   task automatic free(input qca_rel_t r);
      rel_o <= r;
      @(posedge clk_i);
      rel_o <= {1'b0, ~r[$bits(qca_rel_t)-2:0]};
      @(posedge clk_i);
   endtask
endmodule

// [verif/qca_core_tb.sv]
// self-checking bench for the congestion accounting core
// assumes the forwarder stand-in and the checker compile first
`timescale 1ns/1ps
module qca_core_tb;
   import qca_pkg::*;
   // decision codes {valid, accept, discard, stall}
   localparam logic [31:0] D_ACC = 32'hc;
   localparam logic [31:0] D_DIS = 32'ha;
   localparam logic [31:0] D_STL = 32'h9;
   logic        clk_i;            // core clock
   logic        rst_i;            // core reset
   logic        cyc, stb, we;     // bus request
   logic [3:0]  sel;              // bus byte lanes
   logic [31:0] adr, dat;         // bus address and write data
   logic [31:0] rdat;             // bus read data
   logic        ack;              // bus answer
   logic [31:0] q;                // last read value
   qca_req_t    req;              // copy request
   qca_rel_t    rel;              // copy release
   qca_dec_t    dec, d;           // decision out, last taken
   logic [31:0] pause;            // pause levels
   int          n_fail, samples_checked, cycles;

   qca_core qca_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .req_i(req), .rel_i(rel), .dec_o(dec), .pause_o(pause));
   qca_fwd_model qca_fwd_model_i (.clk_i(clk_i), .req_o(req), .rel_o(rel), .dec_i(dec));

   // 100 ns clock
   initial clk_i = 1'b0;
   always #50 clk_i = ~clk_i;
   // hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         wrap_up();
      end
   end
   // verdict
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // value compare
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // classic single bus cycle, waits for ack
   task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] v);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'h3;
      adr <= {22'h0, idx, 2'h0};
      dat <= v;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   // copy of a port 0 class 2 frame
   function automatic qca_req_t mk(input logic [1:0] ds, input logic [1:0] dp,
         input logic dm, input logic f, input logic [13:0] len);
      return '{1'b1, 2'd0, ds, 3'd2, dp, dm, f, len};
   endfunction
   // release of one 700-byte copy to port 1
   localparam qca_rel_t REL1 = '{1'b1, 2'd0, 2'd1, 3'd2, 1'b0, 14'd700};

   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      sel = 4'h0;
      adr = '0;
      dat = '0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(0, 8'd2, 0); chk("thr_reset", 32'h0, q);
      wb(0, 8'd200, 0); chk("ctrl_reset", 32'h0, q);
      wb(0, 8'd212, 0); chk("unmapped", 32'h0, q);
      wb(1, 8'd2, 3);
      wb(1, 8'd81, 8);
      wb(1, 8'd98, 10);
      wb(1, 8'd154, 10);
      wb(0, 8'd2, 0); chk("thr_read", 32'h3, q);
      // 4 words against a 3 word reservation still admitted
      qca_fwd_model_i.send(mk(2'd1, 2'd0, 1'b0, 1'b1, 14'd700), d); chk("first", D_ACC, d);
      chk("pause", 32'h4, pause);
      wb(0, 8'd204, 0); chk("imem_pool", 32'h4, q);
      qca_fwd_model_i.send(mk(2'd1, 2'd0, 1'b0, 1'b0, 14'd700), d); chk("second", D_ACC, d);
      wb(0, 8'd204, 0); chk("imem_once", 32'h4, q);
      wb(0, 8'd205, 0); chk("emem_pool", 32'h8, q);
      wb(0, 8'd206, 0); chk("iref_pool", 32'h2, q);
      wb(0, 8'd207, 0); chk("eref_pool", 32'h2, q);
      // memory closed on both sides, references still open
      qca_fwd_model_i.send(mk(2'd1, 2'd0, 1'b0, 1'b0, 14'd700), d); chk("drop", D_DIS, d);
      wb(1, 8'd200, 1);
      qca_fwd_model_i.send(mk(2'd1, 2'd0, 1'b0, 1'b0, 14'd700), d); chk("stall", D_STL, d);
      qca_fwd_model_i.send(mk(2'd1, 2'd0, 1'b1, 1'b0, 14'd700), d); chk("dropmd", D_DIS, d);
      wb(0, 8'd205, 0); chk("emem_kept", 32'h8, q);
      qca_fwd_model_i.free(REL1);
      wb(0, 8'd205, 0); chk("emem_freed", 32'h4, q);
      qca_fwd_model_i.send(mk(2'd1, 2'd0, 1'b0, 1'b0, 14'd700), d); chk("reopen", D_ACC, d);
      // strict sharing with colour ignored
      wb(1, 8'd38, 100);
      wb(1, 8'd45, 32'h7fff);
      qca_fwd_model_i.send(mk(2'd2, 2'd1, 1'b0, 1'b1, 14'd184), d); chk("share", D_ACC, d);
      wb(0, 8'd208, 0); chk("common_use", 32'h2, q);
      wb(1, 8'd45, 0);
      qca_fwd_model_i.send(mk(2'd2, 2'd1, 1'b1, 1'b1, 14'd184), d); chk("colour", D_DIS, d);
      // class reservation on: the class tier absorbs the word, common use stays
      wb(1, 8'd45, 32'h7fff);
      wb(1, 8'd200, 32'h11);
      qca_fwd_model_i.send(mk(2'd2, 2'd1, 1'b0, 1'b1, 14'd184), d);
      chk("class_res", D_ACC, d);
      wb(0, 8'd208, 0); chk("class_tier", 32'h2, q);
      wrap_up();
   end
endmodule

bind qca_core qca_core_asserts qca_core_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .req_i(req_i), .rel_i(rel_i), .dec_o(dec_o), .pause_o(pause_o));
